// ---- urx_pkg.sv ----
package urx_pkg;

  // Character and buffer shape
  localparam int DATA_W = 8;
  localparam int FRAME_W = 10;
  localparam int FERR_BIT = 9;
  localparam int NINTH_BIT = 8;
  localparam int FIFO_DEPTH = 2;
  localparam int CNT_W = 2;
  localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 2'h2;
  localparam logic [CNT_W-1:0] FIFO_ONE = 2'h1;

  // Divisor and baud timer widths
  localparam int DIV_W = 16;
  localparam int ACC_W = 24;
  localparam int PRE_W = 10;
  localparam logic [ACC_W-1:0] ACC_ONE = 24'h000001;
  localparam logic [PRE_W-1:0] PRE_ONE = 10'h001;
  localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
  localparam logic [7:0] DIV_LOW_RESET = 8'h00;

  // Oversampling: sixteen sample ticks per bit period
  localparam logic [ACC_W-1:0] OVS_RATE = 24'h000010;
  localparam logic [3:0] PH_SAMPLE_A = 4'h7;
  localparam logic [3:0] PH_SAMPLE_B = 4'h8;
  localparam logic [3:0] PH_DECIDE = 4'h9;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  // Base clock dividers and auto-baud slow-down (one eighth)
  localparam logic [6:0] BASE_DIV_SLOW = 7'h40;
  localparam logic [6:0] BASE_DIV_MID = 7'h10;
  localparam logic [6:0] BASE_DIV_FAST = 7'h04;
  localparam int ABD_SHIFT = 3;

  // Auto-baud measurement
  localparam logic [DIV_W-1:0] ABD_START_COUNT = 16'h0001;
  localparam logic [DIV_W-1:0] DIV_ONE = 16'h0001;
  localparam logic [2:0] ABD_RISES_AFTER_FIRST = 3'h3;

  // Base clock divider from the two select bits
  function automatic logic [6:0] urx_base_div(input logic wide, input logic hs,
                                              input logic sync_mode);
    logic hs_eff;
    hs_eff = hs & ~sync_mode;
    case ({wide, hs_eff})
      2'b00: urx_base_div = BASE_DIV_SLOW;
      2'b11: urx_base_div = BASE_DIV_FAST;
      default: urx_base_div = BASE_DIV_MID;
    endcase
  endfunction : urx_base_div

  // Two of three vote
  function automatic logic urx_maj3(input logic a, input logic b, input logic c);
    urx_maj3 = (a & b) | (a & c) | (b & c);
  endfunction : urx_maj3

endpackage : urx_pkg

// ---- urx_baud_gen.sv ----
`timescale 1ns/100ps
`default_nettype none
module urx_baud_gen
  import urx_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic [DIV_W-1:0] divisor, // High and low divisor pair
  input wire logic wide_divisor_select, // 16-bit divisor when set
  input wire logic high_speed_select, // High speed base clock
  input wire logic sync_mode_select, // Synchronous mode
  input wire logic timer_clear, // Restart the baud timer
  output logic sample_tick, // Sixteen per bit period
  output logic abd_tick // Auto-baud counter advance
);

  logic [ACC_W-1:0] acc_q, acc_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic tick_q, tick_d;
  logic abd_q, abd_d;
  logic [6:0] base;
  logic [DIV_W-1:0] div_n;
  logic [ACC_W-1:0] period;
  logic [ACC_W-1:0] sum;
  logic [PRE_W-1:0] abd_max;

  // Fractional timer: adds sixteen per clock against base*(N+1), so ticks stay exact
  // on average even when the bit period is not a multiple of sixteen clocks.
  // Limitation: at most one tick per clock, so very small divisors run slow.
  always_comb begin
    base = urx_base_div(wide_divisor_select, high_speed_select, sync_mode_select);
    div_n = wide_divisor_select ? divisor : {8'h00, divisor[7:0]};
    period = ACC_W'(base) * (ACC_W'(div_n) + ACC_ONE);
    sum = acc_q + OVS_RATE;
    acc_d = sum;
    tick_d = 1'b0;
    if (timer_clear) begin
      acc_d = '0;
    end else if (sum >= period) begin
      acc_d = sum - period;
      tick_d = 1'b1;
    end
  end

  // Auto-baud prescaler at one eighth of the base clock
  always_comb begin
    abd_max = (PRE_W'(base) << ABD_SHIFT) - PRE_ONE;
    abd_d = 1'b0;
    pre_d = pre_q + PRE_ONE;
    if (pre_q >= abd_max) begin
      pre_d = '0;
      abd_d = 1'b1;
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      acc_q <= '0;
      pre_q <= '0;
      tick_q <= 1'b0;
      abd_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      pre_q <= pre_d;
      tick_q <= tick_d;
      abd_q <= abd_d;
    end
  end

  assign sample_tick = tick_q;
  assign abd_tick = abd_q;

endmodule : urx_baud_gen
`default_nettype wire

// ---- urx_fifo.sv ----
`timescale 1ns/100ps
`default_nettype none
module urx_fifo
  import urx_pkg::*;
(
  input wire logic mclk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic flush, // Empty the buffer
  input wire logic push, // Write one character
  input wire logic [FRAME_W-1:0] push_data, // Error, ninth bit, data
  input wire logic pop, // Drop the top character
  output logic [FRAME_W-1:0] head, // Top character, registered
  output logic valid, // Buffer holds a character
  output logic full // Buffer holds two
);

  logic [FRAME_W-1:0] mem_q [FIFO_DEPTH];
  logic [FRAME_W-1:0] mem_d [FIFO_DEPTH];
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic do_pop;
  logic do_push;

  // Shifting buffer: slot zero is always the top, so the head is a plain register
  always_comb begin
    mem_d = mem_q;
    cnt_d = cnt_q;
    do_pop = pop && (cnt_q != '0);
    do_push = push && ((cnt_q != FIFO_FULL_CNT) || do_pop);
    if (do_pop) begin
      for (int i = 0; i < FIFO_DEPTH - 1; i++) begin
        mem_d[i] = mem_q[i+1];
      end
      cnt_d = cnt_q - FIFO_ONE;
    end
    if (do_push) begin
      mem_d[cnt_d[0]] = push_data;
      cnt_d = cnt_d + FIFO_ONE;
    end
    if (flush) begin
      cnt_d = '0;
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      cnt_q <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        mem_q[i] <= '0;
      end
    end else begin
      cnt_q <= cnt_d;
      mem_q <= mem_d;
    end
  end

  assign head = mem_q[0];
  assign valid = (cnt_q != '0);
  assign full = (cnt_q == FIFO_FULL_CNT);

endmodule : urx_fifo
`default_nettype wire

// ---- urx_receiver.sv ----
// Behaviour
// - Divisor 8-bit by default, 16-bit when wide
// - Free-running timer period set by divisor pair
// - Speed select ignored in synchronous mode
// - Base clock oscillator over 64, 16, 4
// - Auto-baud counter at one eighth base rate
// - Divisor write restarts baud timer at once
// - Auto-baud start holds receiver off, receiver_idle low
// - Count from first rise to fifth rise
// - Finish: keep count, clear enable, set flag
// - Both divisor bytes count as 16 bits
// - Measurement counter starts at one
// - With wake-on-break, measure byte after break
// - Character into buffer sets receive flag
// - Clearing receive enable clears overrun
// - Address mode with nine-bit receive admits only ninth-bit-set characters
// - Address mode off admits every character
// - Sixteen-times sampling, majority vote at centre
// - Two-deep buffer, third character sets overrun
`timescale 1ns/100ps
`default_nettype none
module urx_receiver
  import urx_pkg::*;
(
  input wire logic mclk, // System clock, 20 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic rx_pin, // Serial receive line
  input wire logic port_enable, // Port on; low resets the unit
  input wire logic sync_mode_select, // Synchronous mode, receiver off
  input wire logic continuous_receive_enable, // Receiver on
  input wire logic nine_bit_receive, // Nine data bits
  input wire logic address_detect_enable, // Address filtering
  input wire logic high_speed_select, // High speed base clock
  input wire logic wide_divisor_select, // 16-bit divisor
  input wire logic wake_on_break_enable, // Calibrate after a break
  input wire logic receive_irq_enable, // Interrupt gate
  input wire logic autobaud_start, // Pulse: set autobaud_enable
  input wire logic divisor_write_high, // Pulse: write high divisor
  input wire logic divisor_write_low, // Pulse: write low divisor
  input wire logic [7:0] divisor_wdata, // Divisor write data
  input wire logic data_read, // Pulse: read receive_data_reg
  output logic [7:0] baud_divisor_high, // High divisor byte
  output logic [7:0] baud_divisor_low, // Low divisor byte
  output logic autobaud_enable, // Calibration in progress
  output logic [7:0] receive_data, // Top character data
  output logic ninth_bit, // Top character ninth bit
  output logic framing_error, // Top character framing error
  output logic overrun_error, // Overrun flag
  output logic receive_flag, // Unread character or calibration done
  output logic receive_irq, // Interrupt request
  output logic receiver_idle // No reception in progress
);

  typedef enum logic [2:0] {
    AB_OFF, AB_BREAK_LOW, AB_BREAK_HIGH, AB_START, AB_FIRST_RISE, AB_MEASURE
  } urx_ab_state_t;

  typedef enum logic [1:0] {
    RX_IDLE, RX_START, RX_DATA, RX_STOP
  } urx_rx_state_t;

  logic [2:0] sync_q, sync_d;
  logic rx_q, rx_d;
  logic rx_rise;
  logic rx_fall;

  urx_ab_state_t ab_state_q, ab_state_d;
  logic autobaud_enable_q, autobaud_enable_d;
  logic [2:0] rises_q, rises_d;
  logic abd_flag_q, abd_flag_d;
  logic [7:0] div_hi_q, div_hi_d;
  logic [7:0] div_lo_q, div_lo_d;
  logic timer_clear;
  logic abd_done;

  urx_rx_state_t rx_state_q, rx_state_d;
  logic [3:0] phase_q, phase_d;
  logic [3:0] bits_q, bits_d;
  logic [8:0] shift_q, shift_d;
  logic [1:0] maj_q, maj_d;
  logic overrun_error_q, overrun_error_d;
  logic rx_enable;
  logic bit_val;
  logic [3:0] bits_total;
  logic [7:0] char_data;
  logic char_ninth;
  logic push;
  logic [FRAME_W-1:0] push_data;

  logic sample_tick;
  logic abd_tick;
  logic [FRAME_W-1:0] head;
  logic fifo_valid;
  logic fifo_full;

  // Line filter: third stage must match the second before the level changes
  always_comb begin
    sync_d = {sync_q[1:0], rx_pin};
    rx_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : rx_q;
    rx_rise = rx_d & ~rx_q;
    rx_fall = ~rx_d & rx_q;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      sync_q <= 3'h7;
      rx_q <= 1'b1;
    end else begin
      sync_q <= sync_d;
      rx_q <= rx_d;
    end
  end

  // Divisor pair and auto-baud sequencer
  always_comb begin
    ab_state_d = ab_state_q;
    autobaud_enable_d = autobaud_enable_q;
    rises_d = rises_q;
    div_hi_d = div_hi_q;
    div_lo_d = div_lo_q;
    timer_clear = autobaud_enable_q;
    abd_done = 1'b0;
    if (divisor_write_high) begin
      div_hi_d = divisor_wdata;
      timer_clear = 1'b1;
    end
    if (divisor_write_low) begin
      div_lo_d = divisor_wdata;
      timer_clear = 1'b1;
    end
    case (ab_state_q)
      AB_OFF: begin
        if (autobaud_start) begin
          autobaud_enable_d = 1'b1;
          ab_state_d = wake_on_break_enable ? AB_BREAK_LOW : AB_START;
        end
      end
      AB_BREAK_LOW: begin
        if (rx_fall) begin
          ab_state_d = AB_BREAK_HIGH;
        end
      end
      AB_BREAK_HIGH: begin
        if (rx_rise) begin
          ab_state_d = AB_START;
        end
      end
      AB_START: begin
        if (rx_fall) begin
          ab_state_d = AB_FIRST_RISE;
        end
      end
      AB_FIRST_RISE: begin
        if (rx_rise) begin
          {div_hi_d, div_lo_d} = ABD_START_COUNT;
          rises_d = '0;
          ab_state_d = AB_MEASURE;
        end
      end
      AB_MEASURE: begin
        // Wraps silently past 16 bits; a zero high byte is the user's overflow check
        if (abd_tick) begin
          {div_hi_d, div_lo_d} = {div_hi_q, div_lo_q} + DIV_ONE;
        end
        if (rx_rise) begin
          rises_d = rises_q + 3'h1;
          if (rises_q == ABD_RISES_AFTER_FIRST) begin
            abd_done = 1'b1;
            autobaud_enable_d = 1'b0;
            ab_state_d = AB_OFF;
          end
        end
      end
      default: begin
        ab_state_d = AB_OFF;
        autobaud_enable_d = 1'b0;
      end
    endcase
    // Calibration event beats a read in the same cycle
    abd_flag_d = abd_done | (abd_flag_q & ~data_read);
    if (!port_enable) begin
      ab_state_d = AB_OFF;
      autobaud_enable_d = 1'b0;
      abd_flag_d = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      ab_state_q <= AB_OFF;
      autobaud_enable_q <= 1'b0;
      rises_q <= '0;
      abd_flag_q <= 1'b0;
      div_hi_q <= DIV_HIGH_RESET;
      div_lo_q <= DIV_LOW_RESET;
    end else begin
      ab_state_q <= ab_state_d;
      autobaud_enable_q <= autobaud_enable_d;
      rises_q <= rises_d;
      abd_flag_q <= abd_flag_d;
      div_hi_q <= div_hi_d;
      div_lo_q <= div_lo_d;
    end
  end

  // Character recovery; an overrun stalls reception until receive enable drops
  always_comb begin
    rx_enable = port_enable & continuous_receive_enable & ~sync_mode_select
                & ~autobaud_enable_q & ~overrun_error_q;
    rx_state_d = rx_state_q;
    phase_d = phase_q;
    bits_d = bits_q;
    shift_d = shift_q;
    maj_d = maj_q;
    push = 1'b0;
    bit_val = urx_maj3(maj_q[0], maj_q[1], rx_d);
    bits_total = nine_bit_receive ? BITS_NINE : BITS_EIGHT;
    char_data = nine_bit_receive ? shift_q[7:0] : shift_q[8:1];
    char_ninth = nine_bit_receive & shift_q[8];
    push_data = {~bit_val, char_ninth, char_data};
    overrun_error_d = overrun_error_q & continuous_receive_enable & port_enable;
    if (!rx_enable) begin
      rx_state_d = RX_IDLE;
    end else if (rx_state_q == RX_IDLE) begin
      if (rx_fall) begin
        rx_state_d = RX_START;
        phase_d = '0;
      end
    end else if (sample_tick) begin
      phase_d = phase_q + 4'h1;
      if (phase_q == PH_SAMPLE_A) begin
        maj_d[0] = rx_d;
      end
      if (phase_q == PH_SAMPLE_B) begin
        maj_d[1] = rx_d;
      end
      if (phase_q == PH_DECIDE) begin
        case (rx_state_q)
          RX_START: begin
            rx_state_d = bit_val ? RX_IDLE : RX_DATA; // False start aborts quietly
            bits_d = '0;
          end
          RX_DATA: begin
            shift_d = {bit_val, shift_q[8:1]};
            bits_d = bits_q + 4'h1;
            if (bits_q + 4'h1 == bits_total) begin
              rx_state_d = RX_STOP;
            end
          end
          RX_STOP: begin
            rx_state_d = RX_IDLE;
            if (!(address_detect_enable && nine_bit_receive && !char_ninth)) begin
              if (fifo_full) begin
                overrun_error_d = 1'b1;
              end else begin
                push = 1'b1;
              end
            end
          end
          default: begin
            rx_state_d = RX_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rx_state_q <= RX_IDLE;
      phase_q <= '0;
      bits_q <= '0;
      shift_q <= '0;
      maj_q <= '0;
      overrun_error_q <= 1'b0;
    end else begin
      rx_state_q <= rx_state_d;
      phase_q <= phase_d;
      bits_q <= bits_d;
      shift_q <= shift_d;
      maj_q <= maj_d;
      overrun_error_q <= overrun_error_d;
    end
  end

  // Baud timer, held cleared through calibration so it restarts on the result
  urx_baud_gen u_baud (
    .mclk(mclk),
    .reset_n(reset_n),
    .divisor({div_hi_q, div_lo_q}),
    .wide_divisor_select(wide_divisor_select),
    .high_speed_select(high_speed_select),
    .sync_mode_select(sync_mode_select),
    .timer_clear(timer_clear),
    .sample_tick(sample_tick),
    .abd_tick(abd_tick)
  );

  // Two-character buffer; port disable empties it
  urx_fifo u_fifo (
    .mclk(mclk),
    .reset_n(reset_n),
    .flush(~port_enable),
    .push(push),
    .push_data(push_data),
    .pop(data_read),
    .head(head),
    .valid(fifo_valid),
    .full(fifo_full)
  );

  // Status view: divisor pair, calibration, top character and flags
  assign baud_divisor_high = div_hi_q;
  assign baud_divisor_low = div_lo_q;
  assign autobaud_enable = autobaud_enable_q;
  assign receive_data = head[7:0];
  assign ninth_bit = fifo_valid & head[NINTH_BIT];
  assign framing_error = fifo_valid & head[FERR_BIT];
  assign overrun_error = overrun_error_q;
  assign receive_flag = fifo_valid | abd_flag_q;
  assign receive_irq = receive_flag & receive_irq_enable;
  assign receiver_idle = (rx_state_q == RX_IDLE) & ~autobaud_enable_q;

endmodule : urx_receiver
`default_nettype wire

// ---- urx_tx_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module urx_tx_model (
  input wire logic mclk, // System clock
  input wire logic send, // Pulse: start one frame
  input wire logic [8:0] data, // Ninth bit and data byte
  input wire logic nine, // Nine data bits
  input wire logic [15:0] bit_clks, // Clocks per bit
  output logic tx_line, // Serial line into the receiver
  output logic busy // Frame in progress
);
  logic [10:0] frame;
  int nb;
  // Start bit, data LSB first, stop bit; the line idles high between frames
  initial begin
    tx_line = 1'h1;
    busy = 1'h0;
    forever begin
      @(posedge mclk);
      if (send === 1'h1) begin
        busy <= 1'h1;
        nb = nine ? 11 : 10;
        frame = nine ? {1'h1, data, 1'h0} : {2'h3, data[7:0], 1'h0};
        for (int i = 0; i < nb; i++) begin
          tx_line <= frame[i];
          repeat (bit_clks) @(posedge mclk);
        end
        busy <= 1'h0;
      end
    end
  end
endmodule : urx_tx_model
`default_nettype wire

// ---- urx_checker.sv ----
`timescale 1ns/100ps
`default_nettype none
module urx_checker (
  input wire logic mclk, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic port_enable, // Port on
  input wire logic continuous_receive_enable, // Receiver on
  input wire logic nine_bit_receive, // Nine data bits
  input wire logic address_detect_enable, // Address filtering
  input wire logic receive_irq_enable, // Interrupt gate
  input wire logic divisor_write_high, // High divisor strobe
  input wire logic divisor_write_low, // Low divisor strobe
  input wire logic [7:0] divisor_wdata, // Divisor write data
  input wire logic [7:0] baud_divisor_high, // High divisor byte
  input wire logic [7:0] baud_divisor_low, // Low divisor byte
  input wire logic autobaud_enable, // Calibration running
  input wire logic ninth_bit, // Top ninth bit
  input wire logic overrun_error, // Overrun flag
  input wire logic receive_flag, // Receive flag
  input wire logic receive_irq, // Interrupt request
  input wire logic receiver_idle // Receiver idle
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Request is the flag gated by its enable, nothing more
  property p_irq_gate;
    receive_irq == (receive_flag && receive_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq mismatch");
  // Completion raises the flag in the same edge as the enable drops
  property p_cal_done;
    $fell(autobaud_enable) && port_enable && $past(port_enable) |-> receive_flag;
  endproperty
  a_cal_done: assert property (p_cal_done) else $error("no flag at cal end");
  property p_cal_idle;
    autobaud_enable |-> !receiver_idle;
  endproperty
  a_cal_idle: assert property (p_cal_idle) else $error("idle while calibrating");
  // Writes outside calibration land on the next edge
  property p_div_low;
    divisor_write_low && !autobaud_enable |=> baud_divisor_low == $past(divisor_wdata);
  endproperty
  a_div_low: assert property (p_div_low) else $error("low divisor not written");
  property p_div_high;
    divisor_write_high && !autobaud_enable |=> baud_divisor_high == $past(divisor_wdata);
  endproperty
  a_div_high: assert property (p_div_high) else $error("high divisor not written");
  property p_ovr_clear;
    !continuous_receive_enable |=> !overrun_error;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear) else $error("overrun not cleared");
  // Overrun is sticky while the receiver stays on
  property p_ovr_hold;
    overrun_error && continuous_receive_enable && port_enable |=> overrun_error;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun dropped");
  property p_ovr_full;
    $rose(overrun_error) |-> receive_flag;
  endproperty
  a_ovr_full: assert property (p_ovr_full) else $error("overrun with empty buffer");
  property p_addr;
    $rose(receive_flag) && nine_bit_receive && address_detect_enable
      && !$past(autobaud_enable) |-> ninth_bit;
  endproperty
  a_addr: assert property (p_addr) else $error("data char passed address filter");
endmodule : urx_checker
bind urx_receiver urx_checker urx_checker_inst (.mclk, .reset_n, .port_enable,
  .continuous_receive_enable, .nine_bit_receive, .address_detect_enable, .receive_irq_enable,
  .divisor_write_high, .divisor_write_low, .divisor_wdata, .baud_divisor_high,
  .baud_divisor_low, .autobaud_enable, .ninth_bit, .overrun_error, .receive_flag,
  .receive_irq, .receiver_idle);
`default_nettype wire

// ---- urx_receiver_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module urx_receiver_tb;
  logic mclk, reset_n, rx_pin, port_enable, sync_mode_select, continuous_receive_enable;
  logic nine_bit_receive, address_detect_enable, high_speed_select, wide_divisor_select;
  logic wake_on_break_enable, receive_irq_enable, autobaud_start, divisor_write_high;
  logic divisor_write_low, data_read, ninth_bit, framing_error, overrun_error;
  logic receive_flag, receive_irq, receiver_idle, autobaud_enable, tx_send, tx_busy;
  logic [7:0] divisor_wdata, baud_divisor_high, baud_divisor_low, receive_data;
  logic [8:0] tx_data;
  logic [15:0] tx_bit;
  int num_errors, samples_checked, cycles;
  urx_receiver urx_receiver_inst (.mclk, .reset_n, .rx_pin, .port_enable, .sync_mode_select,
    .continuous_receive_enable, .nine_bit_receive, .address_detect_enable, .high_speed_select,
    .wide_divisor_select, .wake_on_break_enable, .receive_irq_enable, .autobaud_start,
    .divisor_write_high, .divisor_write_low, .divisor_wdata, .data_read, .baud_divisor_high,
    .baud_divisor_low, .autobaud_enable, .receive_data, .ninth_bit, .framing_error,
    .overrun_error, .receive_flag, .receive_irq, .receiver_idle);
  urx_tx_model urx_tx_model_inst (.mclk, .send(tx_send), .data(tx_data),
    .nine(nine_bit_receive), .bit_clks(tx_bit), .tx_line(rx_pin), .busy(tx_busy));
  // 20 MHz clock
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end
  // Hang guard, well above the longest calibration run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 95000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk
  // Measured counts carry one count of phase slack
  task automatic chk_in(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'h1) begin
      num_errors++;
      $display("ERROR t=%0t got %0h exp %0h..%0h", $time, got, lo, hi);
    end
  endtask : chk_in
  task automatic clk(input int n);
    repeat (n) @(posedge mclk);
  endtask : clk
  task automatic wr_div(input logic [7:0] hi, input logic [7:0] lo);
    @(posedge mclk);
    divisor_write_high <= 1'h1;
    divisor_wdata <= hi;
    @(posedge mclk);
    divisor_write_high <= 1'h0;
    divisor_write_low <= 1'h1;
    divisor_wdata <= lo;
    @(posedge mclk);
    divisor_write_low <= 1'h0;
    #1;
    chk({baud_divisor_high, baud_divisor_low}, {hi, lo});
  endtask : wr_div
  task automatic send(input logic [8:0] d, input logic [15:0] b);
    int n;
    @(posedge mclk);
    tx_data <= d;
    tx_bit <= b;
    tx_send <= 1'h1;
    @(posedge mclk);
    tx_send <= 1'h0;
    n = 0;
    @(posedge mclk);
    while (tx_busy === 1'h1 && n < 50000) begin
      @(posedge mclk);
      n++;
    end
    // A stuck partner counts as a mismatch
    if (n >= 50000) num_errors++;
    clk(4);
    #1;
  endtask : send
  task automatic rd();
    @(posedge mclk);
    data_read <= 1'h1;
    @(posedge mclk);
    data_read <= 1'h0;
    clk(1);
    #1;
  endtask : rd
  task automatic t_reset();
    #1;
    chk({baud_divisor_high, baud_divisor_low}, 16'h0000);
    chk({autobaud_enable, receive_flag, overrun_error, receiver_idle}, 16'h1);
  endtask : t_reset
  // One character per rate selection; a wrong period corrupts the byte
  task automatic t_rates();
    logic [1:0] sel [4] = '{2'h3, 2'h1, 2'h2, 2'h0};
    logic [7:0] lo [4] = '{8'h03, 8'h00, 8'h01, 8'h00};
    logic [7:0] dat [4] = '{8'hA5, 8'h3C, 8'hC3, 8'h5A};
    int base;
    int nn;
    for (int i = 0; i < 4; i++) begin
      chk(receiver_idle, 1'h1);
      @(posedge mclk);
      wide_divisor_select <= sel[i][1];
      high_speed_select <= sel[i][0];
      receive_irq_enable <= (i != 2);
      wr_div((i == 1) ? 8'h01 : 8'h00, lo[i]);
      base = (sel[i] == 2'h3) ? 4 : (sel[i] == 2'h0) ? 64 : 16;
      nn = sel[i][1] ? {((i == 1) ? 8'h01 : 8'h00), lo[i]} : lo[i];
      send({1'h0, dat[i]}, base * (nn + 1));
      chk({receive_flag, receive_irq, framing_error, ninth_bit}, (i == 2) ? 16'h8 : 16'hC);
      chk(receive_data, dat[i]);
      rd();
      chk(receive_flag, 1'h0);
    end
  endtask : t_rates
  task automatic t_overrun();
    @(posedge mclk);
    wide_divisor_select <= 1'h1;
    high_speed_select <= 1'h1;
    wr_div(8'h00, 8'h03);
    send(9'h011, 16'h0010);
    send(9'h022, 16'h0010);
    send(9'h033, 16'h0010);
    chk({overrun_error, receive_flag, receive_data}, 16'h311);
    rd();
    chk(receive_data, 8'h22);
    rd();
    chk(receive_flag, 1'h0);
    send(9'h044, 16'h0010);
    chk({overrun_error, receive_flag}, 16'h2);
    @(posedge mclk);
    continuous_receive_enable <= 1'h0;
    clk(1);
    #1;
    chk(overrun_error, 1'h0);
    @(posedge mclk);
    continuous_receive_enable <= 1'h1;
  endtask : t_overrun
  task automatic t_address();
    @(posedge mclk);
    nine_bit_receive <= 1'h1;
    address_detect_enable <= 1'h1;
    send(9'h012, 16'h0010);
    chk(receive_flag, 1'h0);
    send(9'h134, 16'h0010);
    chk({receive_flag, ninth_bit, receive_data}, 16'h334);
    rd();
    @(posedge mclk);
    address_detect_enable <= 1'h0;
    send(9'h056, 16'h0010);
    chk({receive_flag, ninth_bit, receive_data}, 16'h256);
    rd();
    @(posedge mclk);
    nine_bit_receive <= 1'h0;
  endtask : t_address
  // Count is bit time over base clock, plus the starting one
  task automatic t_autobaud();
    logic [1:0] sel [3] = '{2'h3, 2'h1, 2'h0};
    logic [15:0] bt [3] = '{16'h0040, 16'h1040, 16'h0200};
    int base;
    int ex;
    for (int i = 0; i < 3; i++) begin
      @(posedge mclk);
      wide_divisor_select <= sel[i][1];
      high_speed_select <= sel[i][0];
      wake_on_break_enable <= (i == 2);
      autobaud_start <= 1'h1;
      @(posedge mclk);
      autobaud_start <= 1'h0;
      clk(1);
      #1;
      chk({autobaud_enable, receiver_idle}, 16'h2);
      base = (sel[i] == 2'h3) ? 4 : (sel[i] == 2'h0) ? 64 : 16;
      ex = 1 + bt[i] / base;
      // Last pass: an all-zero break goes first and must not be measured
      if (i == 2) send(9'h000, bt[i]);
      send(9'h055, bt[i]);
      chk({autobaud_enable, receive_flag}, 16'h1);
      chk_in({baud_divisor_high, baud_divisor_low}, ex - 1, ex + 1);
      if (i == 2) chk(baud_divisor_high, 8'h00);
      rd();
      chk(receive_flag, 1'h0);
    end
  endtask : t_autobaud
  initial begin
    reset_n = 1'h0;
    port_enable = 1'h1;
    continuous_receive_enable = 1'h1;
    receive_irq_enable = 1'h1;
    wide_divisor_select = 1'h1;
    high_speed_select = 1'h1;
    {sync_mode_select, nine_bit_receive, address_detect_enable, wake_on_break_enable} = 4'h0;
    {autobaud_start, divisor_write_high, divisor_write_low, data_read, tx_send} = 5'h00;
    divisor_wdata = 8'h00;
    tx_data = 9'h000;
    tx_bit = 16'h0010;
    repeat (4) @(posedge mclk);
    reset_n <= 1'h1;
    clk(1);
    t_reset();
    t_rates();
    t_overrun();
    t_address();
    t_autobaud();
    report_and_stop();
  end
endmodule : urx_receiver_tb
`default_nettype wire
